// file: verilog/dma_chain_start.sv
// Purpose: Start logic and chain walker for one descriptor DMA channel
// Assumes: Memory answers each read with one rvalid pulse, in order
// Notes: The transfer datapath sits outside and reports completion
//
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none
// Behaviour
// - 32-bit base pointer plus start bit 31
// - Base pointer held unchanged while channel runs
// - Base pointer reads zero while channel active
// - Base pointer treated as quad-word aligned
// - Descriptor processed only with owner bit 31
// - Walk stops after descriptor with bit 28
// - Bit 27 requests done interrupt after descriptor
module dma_chain_start (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire dma_chain_pkg::reg_req_t bus_i,
    output dma_chain_pkg::word_t rdata_o,
    output logic mem_rd_o,
    output dma_chain_pkg::word_t mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire dma_chain_pkg::word_t mem_rdata_i,
    output dma_chain_pkg::desc_t desc_o,
    output logic desc_valid_o,
    input wire logic desc_ready_i,
    input wire logic xfer_done_i,
    output logic irq_o
);
    import dma_chain_pkg::*;

    chan_state_t state; // Channel state
    chan_state_t next_state;
    word_t base; // First descriptor pointer
    word_t next_base;
    word_t ptr; // Address of descriptor being walked
    word_t next_ptr;
    logic [1:0] word_idx; // Descriptor word being fetched
    logic [1:0] next_word_idx;
    logic wait_rsp; // Read issued, answer pending
    logic next_wait_rsp;
    desc_t next_desc;
    logic next_desc_valid;
    logic next_mem_rd;
    word_t next_mem_addr;
    word_t next_rdata;
    logic [EV_W-1:0] events; // One-cycle event pulses
    logic active; // Channel busy walking a chain
    logic start_req; // Start bit written
    logic base_wr; // Write to base pointer
    logic stat_rd; // Read of status register
    logic mask_wr; // Write to mask register
    logic [EV_W-1:0] ev_status; // Sticky events
    logic [EV_W-1:0] ev_mask; // Event mask
    desc_flags_t flags; // Flags of the held descriptor

    assign active = (state != ST_IDLE);
    assign start_req = bus_i.wr && (bus_i.addr == OFF_CONFIG)
        && bus_i.wdata[START_BIT];
    assign base_wr = bus_i.wr && (bus_i.addr == OFF_BASE);
    assign stat_rd = bus_i.rd && (bus_i.addr == OFF_STATUS);
    assign mask_wr = bus_i.wr && (bus_i.addr == OFF_MASK);

    // Flags of the descriptor already fetched
    desc_flag_decode u_flags (
        .status_i(desc_o.status),
        .flags_o(flags)
    );

    // Event status, mask and interrupt line
    irq_status u_irq (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(events),
        .clear_i(stat_rd),
        .mask_wr_i(mask_wr),
        .mask_data_i(bus_i.wdata[EV_W-1:0]),
        .status_o(ev_status),
        .mask_o(ev_mask),
        .irq_o(irq_o)
    );

    // Next values of register file and chain walker
    always_comb
    begin
        next_state = state;
        next_base = base;
        next_ptr = ptr;
        next_word_idx = word_idx;
        next_wait_rsp = wait_rsp;
        next_desc = desc_o;
        next_desc_valid = desc_valid_o;
        next_mem_rd = 1'b0;
        next_mem_addr = mem_addr_o;
        next_rdata = WORD_ZERO;
        events = EV_ZERO;

        // Base pointer only writable while idle
        if (base_wr && !active)
        begin
            next_base = bus_i.wdata;
        end

        // Read data, one cycle after the strobe
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                OFF_CONFIG:
                begin
                    next_rdata[START_BIT] = active;
                end
                OFF_BASE:
                begin
                    // Hidden while the channel walks
                    next_rdata = active ? WORD_ZERO : base;
                end
                OFF_STATUS:
                begin
                    next_rdata[EV_W-1:0] = ev_status;
                end
                OFF_MASK:
                begin
                    next_rdata[EV_W-1:0] = ev_mask;
                end
                OFF_CURRENT:
                begin
                    next_rdata = ptr;
                end
                default:
                begin
                    // Unmapped reads as zero
                    next_rdata = WORD_ZERO;
                end
            endcase
        end

        // Chain walker
        unique case (state)
            ST_IDLE:
            begin
                // Start uses the stored base, aligned
                if (start_req)
                begin
                    next_ptr = {base[31:ALIGN_BITS], ALIGN_ZERO};
                    next_word_idx = W_STATUS;
                    next_wait_rsp = 1'b0;
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (!wait_rsp)
                begin
                    // Issue a read of the next word
                    next_mem_rd = 1'b1;
                    next_mem_addr = {ptr[31:ALIGN_BITS], word_idx, BYTE_ZERO};
                    next_wait_rsp = 1'b1;
                end
                else if (mem_rvalid_i)
                begin
                    next_wait_rsp = 1'b0;
                    unique case (word_idx)
                        W_STATUS: next_desc.status = mem_rdata_i;
                        W_SOURCE: next_desc.source = mem_rdata_i;
                        W_DEST: next_desc.dest = mem_rdata_i;
                        W_NEXT: next_desc.next = mem_rdata_i;
                    endcase
                    if (word_idx == W_NEXT)
                    begin
                        // Owner must be the channel to go on
                        if (desc_o.status[OWNER_BIT])
                        begin
                            next_desc_valid = 1'b1;
                            next_state = ST_HAND;
                        end
                        else
                        begin
                            events[EV_OWN] = 1'b1;
                            next_state = ST_IDLE;
                        end
                    end
                    else
                    begin
                        next_word_idx = word_idx + IDX_STEP;
                    end
                end
            end
            ST_HAND:
            begin
                // Descriptor handed to the transfer datapath
                if (desc_ready_i)
                begin
                    next_desc_valid = 1'b0;
                    next_state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (xfer_done_i)
                begin
                    events[EV_DONE] = flags.irq_req;
                    if (flags.final_desc)
                    begin
                        // Last descriptor ends the walk
                        events[EV_END] = 1'b1;
                        next_state = ST_IDLE;
                    end
                    else
                    begin
                        // Follow the link, base left alone
                        next_ptr = {desc_o.next[31:ALIGN_BITS], ALIGN_ZERO};
                        next_word_idx = W_STATUS;
                        next_state = ST_FETCH;
                    end
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            base <= WORD_ZERO;
            ptr <= WORD_ZERO;
            word_idx <= W_STATUS;
            wait_rsp <= 1'b0;
            desc_o <= '0;
            desc_valid_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_addr_o <= WORD_ZERO;
            rdata_o <= WORD_ZERO;
        end
        else
        begin
            state <= next_state;
            base <= next_base;
            ptr <= next_ptr;
            word_idx <= next_word_idx;
            wait_rsp <= next_wait_rsp;
            desc_o <= next_desc;
            desc_valid_o <= next_desc_valid;
            mem_rd_o <= next_mem_rd;
            mem_addr_o <= next_mem_addr;
            rdata_o <= next_rdata;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Start taken while idle
    sequence s_start_taken;
        start_req && (state == ST_IDLE);
    endsequence

    // First read issued two edges later
    sequence s_first_read;
        ##2 mem_rd_o;
    endsequence

    a_start_fetch_base: assert property (
        s_start_taken |-> s_first_read
            ##0 (mem_addr_o[31:ALIGN_BITS] == base[31:ALIGN_BITS]))
        else $error("first fetch not at base pointer");

    a_base_write_idle: assert property (
        base_wr && !active |=> base == $past(bus_i.wdata))
        else $error("base pointer not stored");

    a_base_held: assert property (
        active && $past(active) |-> base == $past(base))
        else $error("base pointer changed while active");

    a_base_read_zero: assert property (
        bus_i.rd && bus_i.addr == OFF_BASE && active |=> rdata_o == WORD_ZERO)
        else $error("base pointer visible while active");

    a_fetch_aligned: assert property (
        mem_rd_o |-> mem_addr_o[3:2] == $past(word_idx)
            && mem_addr_o[1:0] == BYTE_ZERO)
        else $error("fetch address not quad-word based");

    a_owner_gate: assert property (
        $rose(desc_valid_o) |-> desc_o.status[OWNER_BIT])
        else $error("descriptor handed without owner flag");

    a_final_stops: assert property (
        state == ST_RUN && xfer_done_i && flags.final_desc
            |=> state == ST_IDLE && !mem_rd_o ##1 !mem_rd_o)
        else $error("walk continued past final descriptor");

    a_done_event: assert property (
        state == ST_RUN && xfer_done_i && flags.irq_req
            |=> ev_status[EV_DONE])
        else $error("done interrupt not requested");

    a_link_follow: assert property (
        state == ST_RUN && xfer_done_i && !flags.final_desc
            |=> ptr[31:ALIGN_BITS] == $past(desc_o.next[31:ALIGN_BITS])
            ##1 mem_rd_o)
        else $error("next link not followed");
endmodule
`default_nettype wire

// file: shared/dma_chain_pkg.sv
// Purpose: Shared constants and types for the descriptor chain DMA start
// Assumes: 32-bit register port, 32-bit memory read port
// Notes: Register offsets are byte addresses on the register port
`default_nettype none
package dma_chain_pkg;
    // Register offsets
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_BASE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_CURRENT = 8'h10;
    // Field positions
    localparam int START_BIT = 31;
    localparam int OWNER_BIT = 31;
    localparam int FINAL_BIT = 28;
    localparam int IRQ_BIT = 27;
    // Quad-word alignment: low address bits forced to zero
    localparam int ALIGN_BITS = 4;
    localparam logic [3:0] ALIGN_ZERO = 4'h0;
    localparam logic [1:0] BYTE_ZERO = 2'h0;
    // Reset values
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [2:0] EV_ZERO = 3'h0;
    // Descriptor words: status, source, destination, next link
    localparam logic [1:0] W_STATUS = 2'h0;
    localparam logic [1:0] W_SOURCE = 2'h1;
    localparam logic [1:0] W_DEST = 2'h2;
    localparam logic [1:0] W_NEXT = 2'h3;
    localparam logic [1:0] IDX_STEP = 2'h1;
    // Event bits in status and mask registers
    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_END = 1;
    localparam int EV_OWN = 2;

    typedef logic [31:0] word_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        word_t wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // One descriptor as held in memory
    typedef struct packed {
        word_t status;
        word_t source;
        word_t dest;
        word_t next;
    } desc_t;

    // Flags decoded from a status word
    typedef struct packed {
        logic owner;
        logic final_desc;
        logic irq_req;
    } desc_flags_t;

    // Channel states, Gray coded from idle through fetch and hand to run
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_HAND = 2'b11,
        ST_RUN = 2'b10
    } chan_state_t;
endpackage
`default_nettype wire

// file: verilog/desc_flag_decode.sv
// Purpose: Pull the control flags out of a descriptor status word
// Assumes: Status word held stable by the caller
// Notes: Purely combinational
`default_nettype none
module desc_flag_decode (
    input wire dma_chain_pkg::word_t status_i,
    output dma_chain_pkg::desc_flags_t flags_o
);
    import dma_chain_pkg::*;

    // Flag extraction
    always_comb
    begin
        flags_o.owner = status_i[OWNER_BIT];
        flags_o.final_desc = status_i[FINAL_BIT];
        flags_o.irq_req = status_i[IRQ_BIT];
    end
endmodule
`default_nettype wire

// file: verilog/irq_status.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Status cleared by a read of the status register
// Notes: A set in the clearing cycle survives the clear
`default_nettype none
module irq_status (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [dma_chain_pkg::EV_W-1:0] set_i,
    input wire logic clear_i,
    input wire logic mask_wr_i,
    input wire logic [dma_chain_pkg::EV_W-1:0] mask_data_i,
    output logic [dma_chain_pkg::EV_W-1:0] status_o,
    output logic [dma_chain_pkg::EV_W-1:0] mask_o,
    output logic irq_o
);
    import dma_chain_pkg::*;

    logic [EV_W-1:0] next_status; // Status after this edge
    logic [EV_W-1:0] next_mask; // Mask after this edge

    // Next values: clear first, then sets win
    always_comb
    begin
        next_status = clear_i ? EV_ZERO : status_o;
        next_status = next_status | set_i;
        next_mask = mask_wr_i ? mask_data_i : mask_o;
    end

    // Registers
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            status_o <= EV_ZERO;
            mask_o <= EV_ZERO;
        end
        else
        begin
            status_o <= next_status;
            mask_o <= next_mask;
        end
    end

    // Level interrupt while an unmasked bit stands
    assign irq_o = |(status_o & mask_o);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_set_beats_clear: assert property (
        set_i[EV_DONE] |=> status_o[EV_DONE])
        else $error("done event lost");
endmodule
`default_nettype wire

// file: bench/dma_mem_model.sv
// Purpose: Memory model that answers descriptor word reads
// Assumes: One read outstanding at a time
// Notes: The data line changes every cycle between answers
`default_nettype none
module dma_mem_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic mem_rd_i,
    input wire dma_chain_pkg::word_t mem_addr_i,
    input wire logic [3:0] delay_i,
    output logic mem_rvalid_o,
    output dma_chain_pkg::word_t mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import dma_chain_pkg::*;
    word_t mem [0:63]; // Word store, byte address bits 7:2
    word_t addr_log [$]; // Every requested address, in order
    logic pending; // A read waits for its answer
    logic [3:0] wait_cnt; // Cycles left before answering
    word_t held_addr; // Address of the waiting read

    // Answer each request after the delay chosen by the bench
    always @(posedge clk_i)
    begin
        mem_rvalid_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o; // Idle data flips every cycle
        if (reset_i)
        begin
            // Defined pattern so stale data never looks valid
            pending <= 1'b0;
            mem_rdata_o <= 32'h5A5A_A5A5;
        end
        else if (mem_rd_i)
        begin
            pending <= 1'b1;
            wait_cnt <= delay_i;
            held_addr <= mem_addr_i;
            addr_log.push_back(mem_addr_i);
        end
        else if (pending && wait_cnt == 4'h0)
        begin
            pending <= 1'b0;
            mem_rvalid_o <= 1'b1;
            mem_rdata_o <= mem[held_addr[7:2]];
        end
        else if (pending)
            wait_cnt <= wait_cnt - 4'h1;
    end
endmodule
`default_nettype wire

// file: bench/dma_chain_start_tb_top.sv
// Purpose: Self-checking bench for the descriptor chain start logic
// Assumes: Bench plays software and the transfer datapath
// Notes: Memory sits in its own model; delays set per test
`default_nettype none
module dma_chain_start_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_chain_pkg::*;
    logic clk = 1'b0; // 250 MHz system clock
    logic reset = 1'b1; // Held for 8 cycles
    reg_req_t bus = '0; // Register port request
    word_t rdata; // Register read data
    logic mem_rd; // Memory read pulse
    word_t mem_addr; // Memory read address
    logic mem_rvalid; // Memory answer pulse
    word_t mem_rdata; // Memory answer word
    desc_t desc; // Descriptor offered to datapath
    logic desc_valid; // Descriptor offered
    logic desc_ready = 1'b0; // Datapath accepts
    logic xfer_done = 1'b0; // Datapath finished
    logic irq; // Level interrupt
    logic [3:0] mem_delay = 4'h0; // Memory answer delay
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    dma_chain_start uut (.clk_i(clk), .reset_i(reset), .bus_i(bus),
        .rdata_o(rdata), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
        .mem_rvalid_i(mem_rvalid), .mem_rdata_i(mem_rdata),
        .desc_o(desc), .desc_valid_o(desc_valid),
        .desc_ready_i(desc_ready), .xfer_done_i(xfer_done), .irq_o(irq));
    dma_mem_model model (.clk_i(clk), .reset_i(reset), .mem_rd_i(mem_rd),
        .mem_addr_i(mem_addr), .delay_i(mem_delay),
        .mem_rvalid_o(mem_rvalid), .mem_rdata_o(mem_rdata));

    // Clock generator
    always #2 clk = ~clk;

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input word_t exp, input word_t got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input word_t d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic reg_rd(input logic [7:0] a, output word_t d);
        @(posedge clk);
        bus <= '{addr: a, wdata: WORD_ZERO, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask

    // Accept one descriptor after a stall, then report it finished
    task automatic take_desc(input word_t st, input int hold);
        int n;
        n = 0;
        while (desc_valid !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk("descriptor status", st, desc.status);
        repeat (hold) @(posedge clk);
        #1 chk("valid held", 32'h1, {31'h0, desc_valid});
        @(posedge clk);
        desc_ready <= 1'b1;
        @(posedge clk);
        desc_ready <= 1'b0;
        #1 chk("valid dropped", WORD_ZERO, {31'h0, desc_valid});
        repeat (2) @(posedge clk);
        xfer_done <= 1'b1;
        @(posedge clk);
        xfer_done <= 1'b0;
    endtask

    // Every register reads zero after reset, unmapped too
    task automatic test_reset;
        logic [7:0] offs [6];
        word_t d;
        offs = '{OFF_CONFIG, OFF_BASE, OFF_STATUS, OFF_MASK, OFF_CURRENT,
            8'h14};
        reg_wr(8'h14, 32'hFFFF_FFFF);
        foreach (offs[i])
        begin
            reg_rd(offs[i], d);
            chk("reset value", WORD_ZERO, d);
        end
        chk("irq at reset", WORD_ZERO, {31'h0, irq});
        $display("test reset done");
    endtask

    // Two-descriptor chain with a slow memory and a stalling datapath
    task automatic test_chain;
        word_t d;
        word_t exp;
        mem_delay <= 4'h3;
        model.mem[16] = 32'h8800_000C;
        model.mem[19] = 32'h1000_0083;
        model.mem[32] = 32'h9000_000C;
        model.mem[35] = WORD_ZERO;
        model.addr_log.delete();
        reg_wr(OFF_MASK, 32'h0000_0003);
        reg_wr(OFF_BASE, 32'h1000_0040);
        reg_wr(OFF_CONFIG, 32'h8000_0000);
        reg_rd(OFF_BASE, d);
        chk("base while active", WORD_ZERO, d);
        reg_rd(OFF_CONFIG, d);
        chk("start while active", 32'h1, {31'h0, d[START_BIT]});
        reg_wr(OFF_BASE, 32'h2000_0000);
        take_desc(32'h8800_000C, 0);
        #1 chk("done irq", 32'h1, {31'h0, irq});
        take_desc(32'h9000_000C, 3);
        repeat (3) @(posedge clk);
        reg_rd(OFF_CONFIG, d);
        chk("start after end", WORD_ZERO, {31'h0, d[START_BIT]});
        reg_rd(OFF_BASE, d);
        chk("base kept", 32'h1000_0040, d);
        reg_rd(OFF_CURRENT, d);
        chk("current pointer", 32'h1000_0080, d);
        reg_rd(OFF_STATUS, d);
        chk("status", 32'h0000_0003, d);
        chk("irq cleared", WORD_ZERO, {31'h0, irq});
        chk("fetch count", 32'h8, model.addr_log.size());
        for (int i = 0; i < 8 && i < model.addr_log.size(); i++)
        begin
            exp = (i < 4) ? 32'h1000_0040 : 32'h1000_0080;
            exp = exp + 4 * (i % 4);
            chk("fetch address", exp, model.addr_log[i]);
        end
        $display("test chain done");
    endtask

    // Unowned descriptor at an unaligned base, fault masked then shown
    task automatic test_fault;
        word_t d;
        int seen;
        seen = 0;
        mem_delay <= 4'h0;
        model.mem[48] = 32'h0000_000C;
        model.addr_log.delete();
        reg_wr(OFF_BASE, 32'h0000_00C9);
        reg_wr(OFF_CONFIG, 32'h8000_0000);
        repeat (30)
        begin
            @(posedge clk);
            #1 seen = seen + (desc_valid === 1'b1);
        end
        chk("unowned offered", WORD_ZERO, seen);
        chk("masked irq", WORD_ZERO, {31'h0, irq});
        reg_wr(OFF_MASK, 32'h0000_0007);
        #1 chk("unmasked irq", 32'h1, {31'h0, irq});
        reg_rd(OFF_STATUS, d);
        chk("fault status", 32'h0000_0004, d);
        chk("irq after clear", WORD_ZERO, {31'h0, irq});
        chk("fault fetches", 32'h4, model.addr_log.size());
        chk("aligned fetch", 32'h0000_00C0, model.addr_log[0]);
        $display("test fault done");
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_chain();
        test_fault();
        give_verdict();
    end
endmodule
`default_nettype wire
